// ---- stepper_port_pkg.sv ----
package stepper_port_pkg;

	// ----------------------------------------
	// Command layout
	// ----------------------------------------
	localparam int CMD_BITS    = 12;
	localparam int CNT_W       = 5;
	localparam int DECAY_A_BIT = 11;
	localparam int CODE_A_LO   = 7;
	localparam int POL_A_BIT   = 6;
	localparam int DECAY_B_BIT = 5;
	localparam int CODE_B_LO   = 1;
	localparam int POL_B_BIT   = 0;
	localparam int CODE_W      = 4;
	localparam logic [CODE_W-1:0] CODE_OFF = 4'h0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS  = 100;
	localparam int CHOP_PERIOD_NS = 40000;
	localparam int LOAD_VALID_NS  = 7000;
	localparam int POL_EXTRA_NS   = 4000;
	localparam int CHOP_CYCLES    = CHOP_PERIOD_NS / CLK_PERIOD_NS;
	localparam int LOAD_CYCLES    = (LOAD_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POL_EXTRA_CYC  = POL_EXTRA_NS / CLK_PERIOD_NS;
	localparam int CHOP_W         = 12;
	localparam int LOAD_W         = 8;

	// ----------------------------------------
	// Synchroniser lanes
	// ----------------------------------------
	localparam int SYNC_W    = 6;
	localparam int LANE_SCK  = 0;
	localparam int LANE_CS   = 1;
	localparam int LANE_SDI  = 2;
	localparam int LANE_EN   = 3;
	localparam int LANE_SNSA = 4;
	localparam int LANE_SNSB = 5;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h0a;

endpackage

// ---- input_filter.sv ----
module input_filter #(
	parameter int                W         = 1,
	parameter logic [W-1:0]      RESET_VAL = '0
) (
	input  wire logic         mclk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] stable_q
);

	logic [W-1:0] stage1_q;
	logic [W-1:0] stage2_q;
	logic [W-1:0] stage3_q;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			stage1_q <= RESET_VAL;
			stage2_q <= RESET_VAL;
			stage3_q <= RESET_VAL;
		end else begin
			stage1_q <= pinIn;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
		end
	end

	// A change counts only once two late stages agree
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			stable_q <= RESET_VAL;
		end else begin
			stable_q <= (stage3_q & ~(stage2_q ^ stage3_q)) | (stable_q & (stage2_q ^ stage3_q));
		end
	end

endmodule

// ---- stepper_serial_port.sv ----
module stepper_serial_port #(
	parameter int CHOP_CYC = stepper_port_pkg::CHOP_CYCLES
) (
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic       sck,
	input  wire logic       chipSelect_n,
	input  wire logic       sdi,
	output logic            sdoOut_q,
	output logic            sdoOe_q,
	input  wire logic       driverEnableLow_n,
	input  wire logic       senseInputA,
	input  wire logic       senseInputB,
	output logic            phaseAPolarity,
	output logic            phaseBPolarity,
	output logic            decayModeA,
	output logic            decayModeB,
	output logic [3:0]      currentCodeA,
	output logic [3:0]      currentCodeB,
	output logic            bridgeOutputA,
	output logic            bridgeOutputB,
	output logic            loadValid_q
);

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	logic [stepper_port_pkg::SYNC_W-1:0] pinsRaw;
	logic [stepper_port_pkg::SYNC_W-1:0] pinsS;

	assign pinsRaw = {senseInputB, senseInputA, driverEnableLow_n, sdi, chipSelect_n, sck};

	input_filter #(
		.W         (stepper_port_pkg::SYNC_W),
		.RESET_VAL (stepper_port_pkg::SYNC_RESET)
	) u_filter (
		.mclk     (mclk),
		.reset_n  (reset_n),
		.pinIn    (pinsRaw),
		.stable_q (pinsS)
	);

	logic sckS;
	logic csS_n;
	logic sdiS;
	logic enS_n;
	logic [1:0] senseS;

	assign sckS   = pinsS[stepper_port_pkg::LANE_SCK];
	assign csS_n  = pinsS[stepper_port_pkg::LANE_CS];
	assign sdiS   = pinsS[stepper_port_pkg::LANE_SDI];
	assign enS_n  = pinsS[stepper_port_pkg::LANE_EN];
	assign senseS = {pinsS[stepper_port_pkg::LANE_SNSB], pinsS[stepper_port_pkg::LANE_SNSA]};

	logic sckPrev_q;
	logic csPrev_q;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sckPrev_q <= 1'b0;
			csPrev_q  <= 1'b1;
		end else begin
			sckPrev_q <= sckS;
			csPrev_q  <= csS_n;
		end
	end

	logic sckRise;
	logic sckFall;
	logic csRise;
	logic csFall;

	assign sckRise = sckS & ~sckPrev_q;
	assign sckFall = ~sckS & sckPrev_q;
	assign csRise  = csS_n & ~csPrev_q;
	assign csFall  = ~csS_n & csPrev_q;

	// ----------------------------------------
	// Shift register and framing
	// ----------------------------------------
	logic [stepper_port_pkg::CMD_BITS-1:0] shift_q;
	logic [stepper_port_pkg::CNT_W-1:0]    bitCount_q;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			shift_q    <= '0;
			bitCount_q <= '0;
		end else if (csFall) begin
			bitCount_q <= '0;
		end else if (!csS_n && sckRise) begin
			// Older bits fall off the top, so padding ahead of the command drops out
			shift_q <= {shift_q[stepper_port_pkg::CMD_BITS-2:0], sdiS};
			if (bitCount_q != '1) begin
				bitCount_q <= bitCount_q + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sdoOut_q <= 1'b0;
		end else if ((!csS_n && sckFall) || csFall) begin
			sdoOut_q <= shift_q[stepper_port_pkg::CMD_BITS-1];
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sdoOe_q <= 1'b0;
		end else begin
			sdoOe_q <= ~csS_n & ~enS_n;
		end
	end

	logic cmdValid;

	assign cmdValid = csRise &&
		(bitCount_q >= stepper_port_pkg::CNT_W'(stepper_port_pkg::CMD_BITS));

	// ----------------------------------------
	// Active settings
	// ----------------------------------------
	function automatic logic [3:0] codeOf(input logic [11:0] cmd, input int lo);
		codeOf = cmd[lo +: stepper_port_pkg::CODE_W];
	endfunction

	logic [1:0] pol_q;
	logic [1:0] decay_q;
	logic [3:0] code_q [2];
	logic [1:0] newPol;
	logic [1:0] polChange;

	assign newPol    = {shift_q[stepper_port_pkg::POL_B_BIT], shift_q[stepper_port_pkg::POL_A_BIT]};
	assign polChange = cmdValid ? (newPol ^ pol_q) : 2'h0;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pol_q     <= 2'h0;
			decay_q   <= 2'h0;
			code_q[0] <= stepper_port_pkg::CODE_OFF;
			code_q[1] <= stepper_port_pkg::CODE_OFF;
		end else if (cmdValid) begin
			pol_q     <= newPol;
			decay_q   <= {shift_q[stepper_port_pkg::DECAY_B_BIT],
				shift_q[stepper_port_pkg::DECAY_A_BIT]};
			code_q[0] <= codeOf(shift_q, stepper_port_pkg::CODE_A_LO);
			code_q[1] <= codeOf(shift_q, stepper_port_pkg::CODE_B_LO);
		end
	end

	// ----------------------------------------
	// Choppers
	// ----------------------------------------
	logic [stepper_port_pkg::CHOP_W-1:0] chopCnt_q [2];
	logic [1:0] bridgeOn_q;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			chopCnt_q[0] <= '0;
			chopCnt_q[1] <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (polChange[i] || chopCnt_q[i] == stepper_port_pkg::CHOP_W'(CHOP_CYC - 1)) begin
					chopCnt_q[i] <= '0;
				end else begin
					chopCnt_q[i] <= chopCnt_q[i] + 1'b1;
				end
			end
		end
	end

	// Off-time lasts to the next period; no blanking is modelled
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bridgeOn_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (code_q[i] == stepper_port_pkg::CODE_OFF || polChange[i]) begin
					bridgeOn_q[i] <= 1'b0;
				end else if (chopCnt_q[i] == '0) begin
					bridgeOn_q[i] <= ~senseS[i];
				end else if (senseS[i]) begin
					bridgeOn_q[i] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// Load indicator hold-off
	// ----------------------------------------
	logic [stepper_port_pkg::LOAD_W-1:0] loadCnt_q;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			loadCnt_q   <= '0;
			loadValid_q <= 1'b0;
		end else begin
			if (polChange != 2'h0) begin
				loadCnt_q <= '0;
			end else if (loadCnt_q != stepper_port_pkg::LOAD_W'(stepper_port_pkg::LOAD_CYCLES)) begin
				loadCnt_q <= loadCnt_q + 1'b1;
			end
			loadValid_q <= (polChange == 2'h0) &&
				(loadCnt_q == stepper_port_pkg::LOAD_W'(stepper_port_pkg::LOAD_CYCLES));
		end
	end

	assign phaseAPolarity = pol_q[0];
	assign phaseBPolarity = pol_q[1];
	assign decayModeA     = decay_q[0];
	assign decayModeB     = decay_q[1];
	assign currentCodeA   = code_q[0];
	assign currentCodeB   = code_q[1];
	assign bridgeOutputA  = bridgeOn_q[0];
	assign bridgeOutputB  = bridgeOn_q[1];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence polCmdA;
		cmdValid && polChange[0];
	endsequence

	sequence restartA;
		(chopCnt_q[0] == '0) ##1 (chopCnt_q[0] == 1);
	endsequence

	sdo_float_a: assert property ((csS_n || enS_n) |=> !sdoOe_q)
		else $error("serial output driven while idle");
	short_frame_a: assert property (csRise &&
		bitCount_q < stepper_port_pkg::CNT_W'(stepper_port_pkg::CMD_BITS) |=>
		$stable(pol_q) && $stable(decay_q) && $stable(code_q[0]) && $stable(code_q[1]))
		else $error("short frame changed settings");
	tail_word_a: assert property (cmdValid |=> currentCodeA == $past(shift_q[10:7])
		&& currentCodeB == $past(shift_q[4:1]))
		else $error("command not taken from last twelve bits");
	chain_out_a: assert property (!csS_n && sckFall |=> sdoOut_q == $past(shift_q[11]))
		else $error("chain output wrong bit");
	chop_restart_a: assert property (polCmdA |=> restartA)
		else $error("chopper not restarted");
	trip_hold_a: assert property (chopCnt_q[1] == '0 && senseS[1] |=> !bridgeOn_q[1])
		else $error("bridge on while tripped");
	pol_apply_a: assert property (polCmdA |=> phaseAPolarity == $past(newPol[0]))
		else $error("polarity change late");
	load_wait_a: assert property ((polChange != 2'h0) |=> !loadValid_q [*8])
		else $error("load indicator too early");
	zero_off_a: assert property (code_q[0] == stepper_port_pkg::CODE_OFF |=> !bridgeOn_q[0])
		else $error("coil on with zero code");
	commit_edge_a: assert property ($changed(code_q[0]) |-> $past(cmdValid))
		else $error("settings changed outside commit");

endmodule

// ---- spi_host_model.sv ----
module spi_host_model (
	input  wire logic mclk,
	input  wire logic sdo,
	output logic      sck,
	output logic      chipSelect_n,
	output logic      sdi
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [15:0] seen;

	initial begin
		sck = 1'b0;
		chipSelect_n = 1'b1;
		sdi = 1'b0;
		seen = 16'h0000;
	end

	// ----------------------------------------
	// Frame: clock idles low, bits go MSB first
	// ----------------------------------------
	task automatic shift(input int n, input logic [15:0] w);
		chipSelect_n <= 1'b0;
		repeat (8) @(negedge mclk);
		for (int i = n - 1; i >= 0; i--) begin
			sdi <= w[i];
			repeat (4) @(negedge mclk);
			sck <= 1'b1;
			repeat (4) @(negedge mclk);
			seen <= {seen[14:0], sdo};
			sck <= 1'b0;
		end
		// Released data line must not keep the last bit
		sdi <= ~sdi;
		repeat (4) @(negedge mclk);
	endtask

	task automatic close();
		chipSelect_n <= 1'b1;
	endtask
endmodule

// ---- testbench.sv ----
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int CHOP = 20;

	logic        mclk    = 1'b0;
	logic        reset_n = 1'b0;
	logic        driver_enable_low     = 1'b0;
	logic        snsA    = 1'b0;
	logic        snsB    = 1'b0;
	logic        sdoLast = 1'b0;
	logic        sck, csN, sdi, sdoOut, sdoOe, polA, polB, decA, decB;
	logic        brA, brB, loadValid;
	logic [3:0]  codeA, codeB;
	logic [11:0] act;
	int          err_total = 0;
	int          n_checks  = 0;
	wire logic   sdoPin = sdoOe ? sdoOut : ~sdoLast;

	assign act = {decA, codeA, polA, decB, codeB, polB};
	always #50 mclk = ~mclk;
	always @(posedge mclk) if (sdoOe) sdoLast <= sdoOut;

	stepper_serial_port #(.CHOP_CYC(CHOP)) i_dut (
		.mclk(mclk), .reset_n(reset_n), .sck(sck), .chipSelect_n(csN), .sdi(sdi),
		.sdoOut_q(sdoOut), .sdoOe_q(sdoOe), .driverEnableLow_n(driver_enable_low),
		.senseInputA(snsA), .senseInputB(snsB), .phaseAPolarity(polA),
		.phaseBPolarity(polB), .decayModeA(decA), .decayModeB(decB),
		.currentCodeA(codeA), .currentCodeB(codeB), .bridgeOutputA(brA),
		.bridgeOutputB(brB), .loadValid_q(loadValid));

	spi_host_model i_host (
		.mclk(mclk), .sdo(sdoPin), .sck(sck), .chipSelect_n(csN), .sdi(sdi));

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic hang(input string what);
		err_total++;
		$display("Error %s expected done seen timeout", what);
		report_and_stop();
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic off_for(input int n, input string what);
		for (int i = 0; i < n; i++) begin
			chk(what, 12'h000, {11'h0, brA});
			cyc(1);
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_write();
		chk("reset settings", 12'h000, act);
		i_host.shift(12, 16'h05a6);
		chk("sdo enable", 12'h001, {11'h0, sdoOe});
		chk("settings early", 12'h000, act);
		i_host.close();
		cyc(12);
		chk("settings", 12'h5a6, act);
		chk("sdo enable", 12'h000, {11'h0, sdoOe});
		$display("test write done");
	endtask

	task automatic t_pad();
		int n;
		i_host.shift(16, 16'ha9ca);
		chk("chain out", 12'h5a6, i_host.seen[15:4]);
		i_host.close();
		for (n = 0; polA !== 1'b1; n++) begin
			if (n > CHOP + stepper_port_pkg::POL_EXTRA_CYC) hang("polarity");
			cyc(1);
		end
		chk("bridge b kept", 12'h001, {11'h0, brB});
		chk("load at change", 12'h000, {11'h0, loadValid});
		for (n = 0; loadValid !== 1'b1; n++) begin
			if (n > 200) hang("load valid");
			cyc(1);
		end
		chk("load hold-off", 12'h001, {11'h0, n >= stepper_port_pkg::LOAD_CYCLES});
		chk("settings", 12'h9ca, act);
		$display("test pad done");
	endtask

	task automatic t_short();
		i_host.shift(11, 16'h0fff);
		i_host.close();
		cyc(12);
		chk("settings", 12'h9ca, act);
		$display("test short done");
	endtask

	task automatic t_chop();
		int n;
		snsA = 1'b1;
		snsB = 1'b1;
		cyc(CHOP + 8);
		off_for(2 * CHOP, "bridge a tripped");
		chk("bridge b tripped", 12'h000, {11'h0, brB});
		snsA = 1'b0;
		snsB = 1'b0;
		for (n = 0; brA !== 1'b1; n++) begin
			if (n > CHOP + 8) hang("bridge a on");
			cyc(1);
		end
		driver_enable_low = 1'b1;
		i_host.shift(12, 16'h084a);
		chk("sdo enable", 12'h000, {11'h0, sdoOe});
		i_host.close();
		driver_enable_low = 1'b0;
		cyc(300);
		chk("settings", 12'h84a, act);
		off_for(2 * CHOP, "bridge a code zero");
		$display("test chop done");
	endtask

	initial begin
		#3000000;
		hang("run");
	end

	initial begin
		cyc(8);
		reset_n = 1'b1;
		// Enable has been low since time zero
		cyc(310);
		t_write();
		t_pad();
		t_short();
		t_chop();
		report_and_stop();
	end
endmodule
